// File: cpu_bus_params.svh
`ifndef CPU_BUS_PARAMS_SVH
`define CPU_BUS_PARAMS_SVH

// Port width setting codes.
`define CYC_WIDTH_8 2'b00
`define CYC_WIDTH_16 2'b01
`define CYC_WIDTH_32 2'b10
`define CYC_WIDTH_RSVD 2'b11

// Byte-lane levels.
`define LANES_OFF 4'hf
`define LANE_UNUSED 1'b1

// Bus geometry and burst limits.
`define BUS_DATA_W 32
`define BEAT_CNT_W 3
`define MAX_BEATS 3'h4
`define ONE_BEAT 3'h1
`define WDATA_FIFO_DEPTH 4

`endif

// File: cpu_bus_pkg.sv
`default_nettype none
package cpu_bus_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} cyc_state_t;
   typedef enum logic [1:0] {RESP_OK, RESP_FAULT, RESP_RETRY, RESP_BADWIDTH} resp_t;
endpackage
`default_nettype wire

// File: data_fifo.sv
`include "cpu_bus_params.svh"
`default_nettype none
module data_fifo
#(
   parameter int WIDTH = `BUS_DATA_W,
   parameter int DEPTH = `WDATA_FIFO_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [CW-1:0] count_reg, count_next;
   logic push, pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      if (p == PW'(DEPTH - 1))
         bump = '0;
      else
         bump = p + PW'(1);
   endfunction

   assign in_ready = (count_reg != CW'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      mem_next = mem_reg;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next = count_reg;
      if (flush)
      begin
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         count_next = '0;
      end
      else
      begin
         if (push)
         begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next = bump(wr_ptr_reg);
         end
         if (pop)
            rd_ptr_next = bump(rd_ptr_reg);
         if (push && !pop)
            count_next = count_reg + CW'(1);
         else if (pop && !push)
            count_next = count_reg - CW'(1);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end
      else
      begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
      mem_reg <= mem_next;
   end
endmodule // data_fifo
`default_nettype wire

// File: byte_lane_map.sv
`include "cpu_bus_params.svh"
`default_nettype none
module byte_lane_map
(
   input wire logic active,
   input wire logic [1:0] width_code,
   input wire logic [1:0] addr_low,
   input wire logic [3:0] lane_en,
   output logic [3:0] byte_lane_sel_n
);
   logic hi_en, lo_en;

   // A 16-bit port sees the two enables of the half word that the address selects.
   assign hi_en = addr_low[1] ? lane_en[3] : lane_en[1];
   assign lo_en = addr_low[1] ? lane_en[2] : lane_en[0];

   always_comb
   begin
      byte_lane_sel_n = `LANES_OFF;
      if (active)
      begin
         if (width_code == `CYC_WIDTH_32)
            byte_lane_sel_n = ~lane_en;
         else if (width_code == `CYC_WIDTH_16)
            byte_lane_sel_n = {~hi_en, `LANE_UNUSED, addr_low[1], ~lo_en};
         else if (width_code == `CYC_WIDTH_8)
            byte_lane_sel_n = {`LANE_UNUSED, `LANE_UNUSED, addr_low};
      end
   end
endmodule // byte_lane_map
`default_nettype wire

// File: cpu_bus_cycle_ctrl.sv
`include "cpu_bus_params.svh"
`default_nettype none
// Function
// - The cycle output goes low in the address phase and stays low until the ack of the last item is sampled.
// - The instruction-or-data output is high for fetches and low for data for the whole cycle.
// - The direction output is high for writes and low for reads so transceivers can be steered.
// - The data enable goes low when the address cycle ends and returns high when the data cycle ends; a write also needs a buffered word.
// - A low retry input ends the current bus cycle.
// - A read ignores retry once its first data item has been accepted.
// - A write honours retry in every data cycle, the last one included.
// - The width setting decodes 00 as 8-bit, 01 as 16-bit, 10 as 32-bit, with 11 reserved.
module cpu_bus_cycle_ctrl
   import cpu_bus_pkg::*;
#(
   parameter int DATA_W = `BUS_DATA_W,
   parameter int FIFO_DEPTH = `WDATA_FIFO_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic power_on_init_n,
   input wire logic reset_n,
   input wire logic [1:0] port_width,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_instr,
   input wire logic [DATA_W-1:0] req_addr,
   input wire logic [3:0] req_lanes,
   input wire logic [`BEAT_CNT_W-1:0] req_beats,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [DATA_W-1:0] wr_data,
   output logic rd_valid,
   output logic [DATA_W-1:0] rd_data,
   output logic done,
   output resp_t resp_code,
   output logic cold_boot,
   input wire logic [DATA_W-1:0] ad_in,
   output logic [DATA_W-1:0] ad_out,
   output logic ad_oe,
   output logic cycle_active_n,
   output logic instr_data,
   output logic rd_strobe_n,
   output logic wr_strobe_n,
   output logic data_phase_enable_n,
   output logic transceiver_direction,
   output logic last_data_n,
   output logic [3:0] byte_lane_sel_n,
   input wire logic ack_n,
   input wire logic transfer_fault_n,
   input wire logic retry_n
);
   cyc_state_t state_reg, state_next;
   logic [DATA_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] rd_data_reg, rd_data_next;
   logic [1:0] width_reg, width_next;
   logic [3:0] lanes_reg, lanes_next;
   logic [`BEAT_CNT_W-1:0] beats_reg, beats_next, beat_cnt_reg, beat_cnt_next;
   logic write_reg, write_next, instr_reg, instr_next;
   logic done_reg, done_next, rd_valid_reg, rd_valid_next;
   resp_t resp_reg, resp_next;
   logic cold_reg, cold_next;
   logic rst_all, in_data, beat_last, beat_take, retry_eff, fault, fifo_valid, fifo_pop, fifo_flush;
   logic [DATA_W-1:0] fifo_data;

   function automatic logic [2:0] item_bytes(input logic [1:0] w);
      if (w == `CYC_WIDTH_8)
         item_bytes = 3'h1;
      else if (w == `CYC_WIDTH_16)
         item_bytes = 3'h2;
      else
         item_bytes = 3'h4;
   endfunction

   function automatic logic [`BEAT_CNT_W-1:0] clamp_beats(input logic [`BEAT_CNT_W-1:0] b);
      if (b == '0)
         clamp_beats = `ONE_BEAT;
      else if (b > `MAX_BEATS)
         clamp_beats = `MAX_BEATS;
      else
         clamp_beats = b;
   endfunction

   // Either external reset input parks the bus exactly like the local reset.
   assign rst_all = rst || !power_on_init_n || !reset_n;

   assign in_data = (state_reg == ST_DATA);
   assign beat_last = (beat_cnt_reg == beats_reg - `ONE_BEAT);
   assign fault = in_data && !transfer_fault_n;
   // Once a read item is in, a retry would replay data already handed on, so it is ignored.
   assign retry_eff = in_data && !retry_n && (write_reg || beat_cnt_reg == '0);
   assign beat_take = !data_phase_enable_n && !ack_n;
   assign fifo_pop = in_data && write_reg && beat_take && !fault && !retry_eff;
   assign fifo_flush = in_data && write_reg && (fault || retry_eff);

   // The write data enable waits for a buffered word, which is how the drain side stalls.
   assign data_phase_enable_n = !(in_data && (!write_reg || fifo_valid));
   assign cycle_active_n = (state_reg == ST_IDLE);
   assign instr_data = !cycle_active_n && instr_reg;
   assign transceiver_direction = !cycle_active_n && write_reg;
   assign rd_strobe_n = cycle_active_n || write_reg;
   assign wr_strobe_n = cycle_active_n || !write_reg;
   assign last_data_n = !(in_data && beat_last);
   assign ad_oe = (state_reg == ST_ADDR) || (in_data && write_reg);
   assign ad_out = (state_reg == ST_ADDR) ? addr_reg : (in_data && write_reg) ? fifo_data : '0;
   assign req_ready = (state_reg == ST_IDLE);
   assign rd_valid = rd_valid_reg;
   assign rd_data = rd_data_reg;
   assign done = done_reg;
   assign resp_code = resp_reg;
   assign cold_boot = cold_reg;

   data_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wdata_fifo
   (
      .sys_clk(sys_clk),
      .rst(rst_all),
      .flush(fifo_flush),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   byte_lane_map u_lane_map
   (
      .active(!cycle_active_n),
      .width_code(width_reg),
      .addr_low(addr_reg[1:0]),
      .lane_en(lanes_reg),
      .byte_lane_sel_n(byte_lane_sel_n)
   );

   always_comb
   begin
      state_next = state_reg;
      addr_next = addr_reg;
      rd_data_next = rd_data_reg;
      width_next = width_reg;
      lanes_next = lanes_reg;
      beats_next = beats_reg;
      beat_cnt_next = beat_cnt_reg;
      write_next = write_reg;
      instr_next = instr_reg;
      done_next = 1'b0;
      rd_valid_next = 1'b0;
      resp_next = resp_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (req_valid)
            begin
               if (port_width == `CYC_WIDTH_RSVD)
               begin
                  done_next = 1'b1;
                  resp_next = RESP_BADWIDTH;
               end
               else
               begin
                  state_next = ST_ADDR;
                  addr_next = req_addr;
                  width_next = port_width;
                  lanes_next = req_lanes;
                  beats_next = clamp_beats(req_beats);
                  beat_cnt_next = '0;
                  write_next = req_write;
                  instr_next = req_instr;
               end
            end
         end
         ST_ADDR:
            state_next = ST_DATA;
         ST_DATA:
         begin
            // A fault outranks a retry, and both outrank an ack in the same cycle.
            if (fault)
            begin
               state_next = ST_IDLE;
               done_next = 1'b1;
               resp_next = RESP_FAULT;
            end
            else if (retry_eff)
            begin
               state_next = ST_IDLE;
               done_next = 1'b1;
               resp_next = RESP_RETRY;
            end
            else if (beat_take)
            begin
               if (!write_reg)
               begin
                  rd_data_next = ad_in;
                  rd_valid_next = 1'b1;
               end
               addr_next = addr_reg + {{(DATA_W - 3){1'b0}}, item_bytes(width_reg)};
               if (beat_last)
               begin
                  state_next = ST_IDLE;
                  done_next = 1'b1;
                  resp_next = RESP_OK;
               end
               else
                  beat_cnt_next = beat_cnt_reg + `ONE_BEAT;
            end
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst_all)
      begin
         state_reg <= ST_IDLE;
         addr_reg <= '0;
         rd_data_reg <= '0;
         width_reg <= `CYC_WIDTH_32;
         lanes_reg <= '0;
         beats_reg <= `ONE_BEAT;
         beat_cnt_reg <= '0;
         write_reg <= 1'b0;
         instr_reg <= 1'b0;
         done_reg <= 1'b0;
         rd_valid_reg <= 1'b0;
         resp_reg <= RESP_OK;
      end
      else
      begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         rd_data_reg <= rd_data_next;
         width_reg <= width_next;
         lanes_reg <= lanes_next;
         beats_reg <= beats_next;
         beat_cnt_reg <= beat_cnt_next;
         write_reg <= write_next;
         instr_reg <= instr_next;
         done_reg <= done_next;
         rd_valid_reg <= rd_valid_next;
         resp_reg <= resp_next;
      end
   end

   // Remembers whether the last reset was a power-on one; a warm reset without a power-on one, or the local reset, clears it.
   always_comb
   begin
      cold_next = cold_reg;
      if (!power_on_init_n)
         cold_next = 1'b1;
      else if (!reset_n)
         cold_next = 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         cold_reg <= 1'b0;
      else
         cold_reg <= cold_next;
   end

   AST_CYCLE_END: assert property (@(posedge sys_clk) disable iff (rst_all)
      (in_data && beat_take && beat_last && !fault && !retry_eff) |=> cycle_active_n && done && resp_code == RESP_OK)
      else $error("cycle did not end after the last ack");

   AST_CYCLE_START: assert property (@(posedge sys_clk) disable iff (rst_all)
      $fell(cycle_active_n) |-> ad_oe && data_phase_enable_n ##1 !cycle_active_n)
      else $error("cycle start lacks an address phase");

   AST_ID_STABLE: assert property (@(posedge sys_clk) disable iff (rst_all)
      (!cycle_active_n && !$past(cycle_active_n)) |-> $stable(instr_data))
      else $error("instruction/data indication changed inside a cycle");

   AST_DIRECTION: assert property (@(posedge sys_clk) disable iff (rst_all)
      !cycle_active_n |-> (transceiver_direction == !wr_strobe_n) && (rd_strobe_n != wr_strobe_n))
      else $error("direction disagrees with strobes");

   AST_READ_DEN: assert property (@(posedge sys_clk) disable iff (rst_all)
      ($fell(cycle_active_n) && !transceiver_direction) |=> !data_phase_enable_n)
      else $error("read data enable not asserted after the address cycle");

   AST_DEN_END: assert property (@(posedge sys_clk) disable iff (rst_all)
      !data_phase_enable_n |-> !cycle_active_n && !ad_oe || transceiver_direction)
      else $error("data enable outside a data cycle");

   AST_READ_CAPTURE: assert property (@(posedge sys_clk) disable iff (rst_all)
      (in_data && !write_reg && beat_take && !fault && !retry_eff) |=> rd_valid && rd_data == $past(ad_in))
      else $error("read data not captured on ack");

   AST_FAULT_END: assert property (@(posedge sys_clk) disable iff (rst_all)
      fault |=> cycle_active_n && done && resp_code == RESP_FAULT)
      else $error("bus fault did not end the cycle");

   AST_READ_RETRY_IGNORED: assert property (@(posedge sys_clk) disable iff (rst_all)
      (in_data && !write_reg && beat_cnt_reg != '0 && !retry_n && transfer_fault_n)
      |=> !(done && resp_code == RESP_RETRY))
      else $error("retry honoured after the first read item");

   AST_WRITE_RETRY: assert property (@(posedge sys_clk) disable iff (rst_all)
      (in_data && write_reg && !retry_n && transfer_fault_n) |=> done && resp_code == RESP_RETRY && cycle_active_n)
      else $error("retry not honoured during a write");

   AST_NARROW_LANES: assert property (@(posedge sys_clk) disable iff (rst_all)
      (!cycle_active_n && width_reg == `CYC_WIDTH_8)
      |-> byte_lane_sel_n[3:2] == 2'b11 && byte_lane_sel_n[1:0] == addr_reg[1:0])
      else $error("8-bit lane pattern wrong");

   AST_LAST_FLAG: assert property (@(posedge sys_clk) disable iff (rst_all)
      (!last_data_n && !data_phase_enable_n && !ack_n && transfer_fault_n && retry_n) |=> cycle_active_n && done)
      else $error("last data flag not tied to the final phase");

   AST_BAD_WIDTH: assert property (@(posedge sys_clk) disable iff (rst_all)
      (req_valid && req_ready && port_width == `CYC_WIDTH_RSVD)
      |=> done && resp_code == RESP_BADWIDTH && cycle_active_n)
      else $error("reserved width not refused");

   AST_RESET_PARK: assert property (@(posedge sys_clk)
      (!power_on_init_n || !reset_n) |=> cycle_active_n && data_phase_enable_n)
      else $error("external reset did not park the bus");

   COV_READ_BURST: cover property (@(posedge sys_clk) disable iff (rst_all)
      in_data && !write_reg && beat_take && beat_last && beats_reg == `MAX_BEATS);
   COV_WRITE_STALL: cover property (@(posedge sys_clk) disable iff (rst_all)
      in_data && write_reg && !fifo_valid);
   COV_WRITE_RETRY_LAST: cover property (@(posedge sys_clk) disable iff (rst_all)
      in_data && write_reg && beat_last && !retry_n && transfer_fault_n);
   COV_FAULT: cover property (@(posedge sys_clk) disable iff (rst_all) fault);
endmodule // cpu_bus_cycle_ctrl
`default_nettype wire

// File: mem_responder.sv
`default_nettype none
module mem_responder
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [31:0] ad_out,
   input wire logic ad_oe,
   input wire logic cycle_active_n,
   input wire logic data_phase_enable_n,
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n,
   input wire logic [3:0] wait_cyc,
   input wire logic [3:0] fault_item,
   input wire logic [3:0] retry_item,
   output logic [31:0] ad_in,
   output logic ack_n,
   output logic transfer_fault_n,
   output logic retry_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] addr_reg;
   logic [31:0] held_reg;
   logic [3:0] wait_reg;
   logic [3:0] item_reg;
   logic cyc_prev_reg;
   logic [31:0] wlog [4];
   logic den_on;
   assign den_on = !data_phase_enable_n;
   assign ack_n = !(den_on && wait_reg >= wait_cyc);
   assign transfer_fault_n = !(!ack_n && item_reg == fault_item);
   assign retry_n = !(!ack_n && item_reg == retry_item);
   // A released bus shows the inverse of its last level so stale data never looks valid.
   assign ad_in = (!ack_n && !rd_strobe_n) ? addr_reg + 32'(item_reg) : ~held_reg;
   always_ff @(posedge sys_clk)
   begin
      if (rst || cycle_active_n)
      begin
         wait_reg <= 4'h0;
         item_reg <= 4'h0;
      end
      else if (!ack_n)
      begin
         wait_reg <= 4'h0;
         item_reg <= item_reg + 4'h1;
         if (!wr_strobe_n)
            wlog[item_reg[1:0]] <= ad_out;
      end
      else if (den_on)
         wait_reg <= wait_reg + 4'h1;
      if (!cycle_active_n && cyc_prev_reg && ad_oe)
         addr_reg <= ad_out;
      cyc_prev_reg <= cycle_active_n;
      held_reg <= ad_in;
   end
endmodule // mem_responder
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench
   import cpu_bus_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic wr; logic ins; logic [1:0] pw; logic [31:0] addr; logic [3:0] ln; logic [2:0] bt;
      logic [3:0] wt; logic [3:0] fi; logic [3:0] ri; resp_t rs;} row_t;
   logic sys_clk, rst, power_on_init_n, reset_n, req_valid, req_ready, req_write, req_instr;
   logic wr_valid, wr_ready, rd_valid, done, cold_boot, ad_oe, cycle_active_n, instr_data;
   logic rd_strobe_n, wr_strobe_n, data_phase_enable_n, transceiver_direction, last_data_n;
   logic ack_n, transfer_fault_n, retry_n;
   logic [1:0] port_width;
   logic [31:0] req_addr, wr_data, rd_data, ad_in, ad_out;
   logic [3:0] req_lanes, byte_lane_sel_n, wait_cyc, fault_item, retry_item;
   logic [2:0] req_beats;
   resp_t resp_code;
   int mismatches = 0;
   int checked = 0;
   row_t rows [6] = '{
      '{1'b0, 1'b1, 2'b10, 32'h0000_1000, 4'hf, 3'h1, 4'h0, 4'hf, 4'hf, RESP_OK},
      '{1'b1, 1'b0, 2'b10, 32'h0000_1004, 4'h3, 3'h4, 4'h1, 4'hf, 4'hf, RESP_OK},
      '{1'b0, 1'b0, 2'b01, 32'h0000_2002, 4'hc, 3'h2, 4'h2, 4'hf, 4'hf, RESP_OK},
      '{1'b1, 1'b0, 2'b01, 32'h0000_2000, 4'h3, 3'h3, 4'h0, 4'hf, 4'hf, RESP_OK},
      '{1'b0, 1'b0, 2'b00, 32'h0000_3003, 4'h1, 3'h4, 4'h0, 4'hf, 4'hf, RESP_OK},
      '{1'b1, 1'b0, 2'b00, 32'h0000_3001, 4'h1, 3'h1, 4'h3, 4'hf, 4'hf, RESP_OK}};

   cpu_bus_cycle_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .power_on_init_n(power_on_init_n), .reset_n(reset_n),
      .port_width(port_width), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
      .req_instr(req_instr), .req_addr(req_addr), .req_lanes(req_lanes), .req_beats(req_beats),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
      .done(done), .resp_code(resp_code), .cold_boot(cold_boot), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .cycle_active_n(cycle_active_n), .instr_data(instr_data), .rd_strobe_n(rd_strobe_n),
      .wr_strobe_n(wr_strobe_n), .data_phase_enable_n(data_phase_enable_n),
      .transceiver_direction(transceiver_direction), .last_data_n(last_data_n),
      .byte_lane_sel_n(byte_lane_sel_n), .ack_n(ack_n), .transfer_fault_n(transfer_fault_n), .retry_n(retry_n));

   mem_responder pm_u (.sys_clk(sys_clk), .rst(rst), .ad_out(ad_out), .ad_oe(ad_oe),
      .cycle_active_n(cycle_active_n), .data_phase_enable_n(data_phase_enable_n), .rd_strobe_n(rd_strobe_n),
      .wr_strobe_n(wr_strobe_n), .wait_cyc(wait_cyc), .fault_item(fault_item), .retry_item(retry_item),
      .ad_in(ad_in), .ack_n(ack_n), .transfer_fault_n(transfer_fault_n), .retry_n(retry_n));

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      checked++;
      // An unknown result must count as a mismatch, not slip through.
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("BAD t=%0t %s", $time, msg);
      end
   endtask

   function automatic logic [3:0] lanes_exp(row_t r);
      case (r.pw)
         2'b10: return ~r.ln;
         2'b01: return r.addr[1] ? {~r.ln[3], 2'b11, ~r.ln[2]} : {~r.ln[1], 2'b10, ~r.ln[0]};
         default: return {2'b11, r.addr[1:0]};
      endcase
   endfunction

   task automatic push(input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      #1 wr_valid = 1'b1;
      wr_data = d;
      for (k = 0; k < 50 && !wr_ready; k++)
         @(negedge sys_clk);
      if (k == 50)
      begin
         chk(1'b0, "write buffer stuck");
         results();
      end
      @(posedge sys_clk);
      #1 wr_valid = 1'b0;
   endtask

   task automatic run(input row_t r);
      int k, cyc, den, last, rv;
      cyc = 0;
      den = 0;
      last = 0;
      rv = 0;
      if (r.wr)
         for (int i = 0; i < r.bt; i++)
            push({r.addr[15:0], 16'(i)});
      // The buffer holds four words, so a fourth push must leave it refusing.
      if (r.wr && r.bt == 3'h4)
         chk(wr_ready === 1'b0, "buffer not full");
      wait_cyc = r.wt;
      fault_item = r.fi;
      retry_item = r.ri;
      @(posedge sys_clk);
      #1 {req_valid, req_write, req_instr, port_width} = {1'b1, r.wr, r.ins, r.pw};
      {req_addr, req_lanes, req_beats} = {r.addr, r.ln, r.bt};
      @(posedge sys_clk);
      #1 req_valid = 1'b0;
      for (k = 0; k < 200; k++)
      begin
         @(negedge sys_clk);
         if (k == 0 && r.pw != 2'b11)
         begin
            chk(byte_lane_sel_n === lanes_exp(r), "lanes");
            chk(ad_oe === 1'b1 && ad_out === r.addr && req_ready === 1'b0, "address phase");
         end
         if (!cycle_active_n)
         begin
            cyc++;
            chk(instr_data === r.ins, "instr flag");
            chk(transceiver_direction === r.wr, "direction");
            chk(rd_strobe_n === r.wr && wr_strobe_n === !r.wr, "strobes");
         end
         else
            chk(data_phase_enable_n === 1'b1 && last_data_n === 1'b1, "strobe outside cycle");
         if (!data_phase_enable_n)
            den++;
         if (!last_data_n)
            last++;
         if (rd_valid === 1'b1)
         begin
            chk(rd_data === r.addr + 32'(rv), "read data");
            rv++;
         end
         if (done === 1'b1)
            break;
      end
      if (k == 200)
      begin
         chk(1'b0, "no done");
         results();
      end
      chk(resp_code === r.rs, "response");
      if (r.rs == RESP_BADWIDTH)
         chk(cyc == 0, "bus cycle on reserved width");
      if (r.rs == RESP_OK)
      begin
         chk(cyc == 1 + r.bt * (r.wt + 1), "cycle length");
         chk(den == r.bt * (r.wt + 1), "data enable length");
         chk(last == r.wt + 1, "last data length");
         chk(rv == (r.wr ? 0 : r.bt), "read items");
         if (r.wr)
            for (int i = 0; i < r.bt; i++)
               chk(pm_u.wlog[i] === {r.addr[15:0], 16'(i)}, "write data");
      end
   endtask

   initial
   begin
      {rst, power_on_init_n, reset_n, req_valid, req_write, req_instr, wr_valid} = 7'h40;
      {port_width, req_addr, req_lanes, req_beats, wr_data} = '0;
      {wait_cyc, fault_item, retry_item} = 12'h0ff;
      repeat (10) @(posedge sys_clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 {power_on_init_n, reset_n} = 2'b11;
      @(negedge sys_clk);
      chk(cold_boot === 1'b1, "cold flag");
      foreach (rows[i])
         run(rows[i]);
      run('{1'b0, 1'b0, 2'b11, 32'h0000_4000, 4'hf, 3'h1, 4'h0, 4'hf, 4'hf, RESP_BADWIDTH});
      run('{1'b0, 1'b0, 2'b10, 32'h0000_5000, 4'hf, 3'h2, 4'h1, 4'h0, 4'hf, RESP_FAULT});
      run('{1'b0, 1'b0, 2'b10, 32'h0000_5100, 4'hf, 3'h2, 4'h0, 4'hf, 4'h0, RESP_RETRY});
      run('{1'b0, 1'b1, 2'b01, 32'h0000_5200, 4'h3, 3'h2, 4'h0, 4'hf, 4'h1, RESP_OK});
      run('{1'b1, 1'b0, 2'b10, 32'h0000_5300, 4'hf, 3'h2, 4'h0, 4'hf, 4'h1, RESP_RETRY});
      run('{1'b1, 1'b0, 2'b10, 32'h0000_5400, 4'hf, 3'h3, 4'h2, 4'h1, 4'hf, RESP_FAULT});
      // A leftover word from an aborted write would show up here as a stuck write buffer.
      run(rows[1]);
      @(posedge sys_clk);
      #1 reset_n = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      @(negedge sys_clk);
      chk(cold_boot === 1'b0 && cycle_active_n === 1'b1, "warm reset");
      run(rows[0]);
      results();
   end
endmodule // testbench
`default_nettype wire
